// >>> hw/shift_and_store_register.sv
// Eight-stage shift register with storage latches and cascade outputs
`default_nettype none

module shift_and_store_register (
   input  wire logic                  CLK_SYS,          // System clock, 125 MHz
   input  wire logic                  RSTN,             // Async reset, active low
   input  wire logic                  SERIAL_IN,        // Serial data input
   input  wire logic                  SHIFT_CLOCK,      // Shift clock pin, sampled
   input  wire logic                  LATCH_LOAD,       // Latch-load strobe
   input  wire logic                  OUTPUT_ENABLE,    // Parallel drive enable
   output logic [7:0]                 PARALLEL_OUT,     // Parallel output values
   output logic [7:0]                 PARALLEL_OUT_OE,  // Parallel output enables
   output logic                       SERIAL_OUT_RISE,  // Cascade out, rising edge
   output logic                       SERIAL_OUT_FALL,  // Cascade out, falling edge
   output logic                       LOAD_READY,       // Latch updates accepted
   output logic                       WORD_VALID,       // Latched word available
   input  wire logic                  WORD_READY,       // Receiver takes word
   output shift_store_pkg::word_t     WORD_DATA         // Latched word stream
);

   // Edge of a sampled level against its previous value
   function automatic logic edge_of(input logic now_lvl, input logic old_lvl);
      edge_of = now_lvl && !old_lvl;
   endfunction

   // State
   logic [7:0]  stage_reg;            // Shift chain
   logic [7:0]  stage_next;           // Chain after this cycle
   logic [7:0]  latch_reg;            // Storage latches
   logic [7:0]  latch_next;           // Latches after this cycle
   logic        shift_clock_old_reg;  // Shift clock one cycle ago
   logic        serial_rise_reg;      // Rising cascade bit
   logic        serial_fall_reg;      // Falling cascade bit
   logic        drive_reg;            // Registered output enable

   // Decode
   wire         clock_rise;           // Shift clock went high
   wire         clock_fall;           // Shift clock went low
   wire         latch_open;           // Latches may follow stages
   wire         latch_change;         // Latches take a new value
   wire         buf_in_ready;         // Buffer has room

   shift_store_pkg::word_t push_word; // Word offered to buffer

   // Edge detection on the sampled shift clock
   // History resets low, the pin's idle level, so reset makes no false edge
   assign clock_rise = edge_of(SHIFT_CLOCK, shift_clock_old_reg);
   assign clock_fall = edge_of(shift_clock_old_reg, SHIFT_CLOCK);

   // Chain advances only on a rising edge, input enters stage 0
   assign stage_next = clock_rise ? {stage_reg[6:0], SERIAL_IN} : stage_reg;

   // Latches transparent while strobe high; buffer full stalls them
   // Holding the load back keeps every word, at the cost of lagging the strobe
   assign latch_open   = LATCH_LOAD && buf_in_ready;
   assign latch_next   = latch_open ? stage_next : latch_reg;
   assign latch_change = latch_next != latch_reg;
   assign push_word    = '{bits: latch_next};

   // Clock history
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         shift_clock_old_reg <= shift_store_pkg::BIT_RST;
      end else begin
         shift_clock_old_reg <= SHIFT_CLOCK;
      end
   end

   // Shift chain
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         stage_reg <= shift_store_pkg::STAGE_RST;
      end else begin
         stage_reg <= stage_next;
      end
   end

   // Storage latches
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         latch_reg <= shift_store_pkg::LATCH_RST;
      end else begin
         latch_reg <= latch_next;
      end
   end

   // Rising cascade output takes the final stage at the rising edge
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         serial_rise_reg <= shift_store_pkg::BIT_RST;
      end else if (clock_rise) begin
         serial_rise_reg <= stage_next[shift_store_pkg::LAST_STAGE];
      end
   end

   // Falling cascade output copies it half a shift clock later
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         serial_fall_reg <= shift_store_pkg::BIT_RST;
      end else if (clock_fall) begin
         serial_fall_reg <= serial_rise_reg;
      end
   end

   // Output drive enable
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         drive_reg <= shift_store_pkg::BIT_RST;
      end else begin
         drive_reg <= OUTPUT_ENABLE;
      end
   end

   // Pins: values always from latches, enables gate the drive
   assign PARALLEL_OUT    = latch_reg;
   assign PARALLEL_OUT_OE = drive_reg ? shift_store_pkg::DRIVE_ALL
                                      : shift_store_pkg::DRIVE_NONE;
   assign SERIAL_OUT_RISE = serial_rise_reg;
   assign SERIAL_OUT_FALL = serial_fall_reg;
   assign LOAD_READY      = buf_in_ready;

   // Every new latch value is queued for the word stream
   word_buffer u_word_buffer (
      .clk       (CLK_SYS),
      .rst_n     (RSTN),
      .in_valid  (latch_change),
      .in_ready  (buf_in_ready),
      .in_data   (push_word),
      .out_valid (WORD_VALID),
      .out_ready (WORD_READY),
      .out_data  (WORD_DATA)
   );

   // Checks on the device's own behaviour
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!RSTN);

   // Shift on rising edge only
   AST_SHIFT_ON_RISE: assert property (
      clock_rise |=> stage_reg == {$past(stage_reg[6:0]), $past(SERIAL_IN)})
      else $error("Shift chain did not advance on rising shift clock");

   AST_CHAIN_HOLDS: assert property (
      !clock_rise |=> $stable(stage_reg))
      else $error("Shift chain moved without a rising shift clock");

   // Latches follow while open, hold while strobe low
   AST_LATCH_FOLLOWS: assert property (
      latch_open |=> latch_reg == $past(stage_next))
      else $error("Latches did not follow the shift stages");

   AST_LATCH_HOLDS: assert property (
      !LATCH_LOAD |=> $stable(latch_reg))
      else $error("Latches changed while latch-load low");

   // Drive and release of the parallel outputs
   AST_DRIVE_ON: assert property (
      OUTPUT_ENABLE |=> PARALLEL_OUT_OE == shift_store_pkg::DRIVE_ALL
                        && PARALLEL_OUT == $past(latch_next))
      else $error("Parallel outputs not driven with latch values");

   AST_RELEASE: assert property (
      !OUTPUT_ENABLE |=> PARALLEL_OUT_OE == shift_store_pkg::DRIVE_NONE)
      else $error("Parallel outputs driven while disabled");

   // Cascade outputs
   AST_RISE_OUT: assert property (
      clock_rise |=> SERIAL_OUT_RISE == stage_reg[7])
      else $error("Rising serial output not the final stage");

   AST_FALL_OUT: assert property (
      clock_fall |=> SERIAL_OUT_FALL == $past(SERIAL_OUT_RISE))
      else $error("Falling serial output did not copy rising output");

   AST_FALL_STABLE: assert property (
      !clock_fall |=> $stable(SERIAL_OUT_FALL))
      else $error("Falling serial output moved without falling edge");

   AST_FINAL_STAGE: assert property (
      (clock_rise ##1 !clock_rise) |-> SERIAL_OUT_RISE == stage_reg[7])
      else $error("Rising serial output lost the final stage bit");

   // A full buffer holds the latches back instead of losing a word
   AST_REFUSED_HOLD: assert property (
      LATCH_LOAD && !LOAD_READY |=> $stable(latch_reg))
      else $error("Latches changed while the word buffer was full");

   // A shift and a load in one edge latch the shifted value
   AST_LATCH_SHIFT_EDGE: assert property (
      latch_open && clock_rise |=> latch_reg == stage_reg)
      else $error("Latches missed the shift of the same edge");

   // Every changed latch word is offered downstream
   AST_WORD_QUEUED: assert property (
      latch_change |=> WORD_VALID)
      else $error("Changed latch word not queued");

   // A stalled receiver sees the head word unchanged
   AST_WORD_HOLDS: assert property (
      WORD_VALID && !WORD_READY |=> WORD_VALID && $stable(WORD_DATA))
      else $error("Queued word changed under a receiver stall");

   // Enable drop still shows the drive for one more cycle
   AST_DRIVE_LAG: assert property (
      $fell(OUTPUT_ENABLE) |-> PARALLEL_OUT_OE == shift_store_pkg::DRIVE_ALL)
      else $error("Parallel drive dropped before the registered enable");

   // The cascade bit is the one that sat in stage six
   AST_CASCADE_BIT: assert property (
      clock_rise |=> SERIAL_OUT_RISE == $past(stage_reg[6]))
      else $error("Rising serial output not the bit shifted into stage seven");

   // Main scenarios
   COV_SHIFT_AND_LOAD: cover property (clock_rise ##[1:20] latch_change);
   COV_BUFFER_STALL:   cover property (LATCH_LOAD && !buf_in_ready);
   COV_FALL_UPDATE:    cover property (clock_rise ##[1:20] clock_fall);
   COV_WORD_TAKEN:     cover property (WORD_VALID && WORD_READY);
   COV_DRIVE_DROP:     cover property ($fell(OUTPUT_ENABLE));

endmodule

`default_nettype wire

// >>> hw/word_buffer.sv
// Shared constants and types, plus the two-entry word buffer
`default_nettype none

package shift_store_pkg;
   localparam int          STAGES      = 8;       // Shift stages and latches
   localparam int          LAST_STAGE  = 7;       // Index of final stage
   localparam logic [7:0]  STAGE_RST   = 8'h00;   // Shift chain after reset
   localparam logic [7:0]  LATCH_RST   = 8'h00;   // Storage latches after reset
   localparam logic [7:0]  DRIVE_ALL   = 8'hff;   // All output enables on
   localparam logic [7:0]  DRIVE_NONE  = 8'h00;   // All outputs released
   localparam logic        BIT_RST     = 1'h0;    // Single-bit reset value

   // One latched parallel word
   typedef struct packed {
      logic [7:0] bits;                           // Latch contents
   } word_t;

   localparam word_t       WORD_RST    = '{bits: 8'h00};  // Empty buffer slot
endpackage

// Two-entry buffer; head slot is the registered read data
module word_buffer (
   input  wire logic                  clk,        // System clock
   input  wire logic                  rst_n,      // Async reset, active low
   input  wire logic                  in_valid,   // Word offered
   output logic                       in_ready,   // Room for a word
   input  wire shift_store_pkg::word_t in_data,   // Offered word
   output logic                       out_valid,  // Head word present
   input  wire logic                  out_ready,  // Receiver takes head
   output shift_store_pkg::word_t     out_data    // Head word, from register
);
   shift_store_pkg::word_t head_reg;              // Oldest word
   shift_store_pkg::word_t tail_reg;              // Second word
   logic                   head_valid_reg;        // Head slot occupied
   logic                   tail_valid_reg;        // Tail slot occupied
   wire                    push;                  // Word written this cycle
   wire                    pop;                   // Word read this cycle

   // Full only when both slots hold words
   assign in_ready  = !tail_valid_reg;
   assign out_valid = head_valid_reg;
   assign out_data  = head_reg;
   assign push      = in_valid && in_ready;
   assign pop       = head_valid_reg && out_ready;

   // Slot bookkeeping; tail moves forward on a read
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         head_reg       <= shift_store_pkg::WORD_RST;
         tail_reg       <= shift_store_pkg::WORD_RST;
         head_valid_reg <= shift_store_pkg::BIT_RST;
         tail_valid_reg <= shift_store_pkg::BIT_RST;
      end else if (pop) begin
         // Refill head from tail, else from incoming word
         head_reg       <= tail_valid_reg ? tail_reg : in_data;
         head_valid_reg <= tail_valid_reg || push;
         tail_valid_reg <= 1'b0;
      end else if (push) begin
         if (!head_valid_reg) begin
            head_reg       <= in_data;
            head_valid_reg <= 1'b1;
         end else begin
            tail_reg       <= in_data;
            tail_valid_reg <= 1'b1;
         end
      end
   end
endmodule

`default_nettype wire

// >>> testbench/host_model.sv
// Host controller model driving the serial, clock, strobe and enable pins
`default_nettype none

module host_model (
   input  wire logic clk,            // System clock
   output logic      serial_in,      // Serial data towards device
   output logic      shift_clock,    // Shift clock pin
   output logic      latch_load,     // Latch strobe
   output logic      output_enable   // Parallel drive enable
);
   timeunit 1ns;
   timeprecision 1ps;

   // Pins idle low from time zero
   initial begin
      serial_in = 1'h0;
      shift_clock = 1'h0;
      latch_load = 1'h0;
      output_enable = 1'h0;
   end

   // Change pins just after the falling edge, held for a full cycle
   task automatic drive(input logic sin, input logic sck, input logic ld, input logic oe);
      @(negedge clk);
      serial_in = sin;
      shift_clock = sck;
      latch_load = ld;
      output_enable = oe;
   endtask
endmodule

`default_nettype wire

// >>> testbench/shift_and_store_register_test.sv
// Self-checking bench comparing the register against a behavioural model
`default_nettype none

module shift_and_store_register_test;
   timeunit 1ns;
   timeprecision 1ps;

   logic                   clk_sys, rstn, word_ready;  // Bench-driven inputs
   logic                   sin, sck, ld, oe;           // Host pins
   logic [7:0]             par, par_oe;                // Parallel outputs
   logic                   srise, sfall, load_ready, word_valid;  // Status outputs
   shift_store_pkg::word_t word_data;                  // Buffered word
   int                     bad_count, compares, seed, cycles;  // Counters
   logic [7:0]             stage, latch, q[$];         // Model state
   logic                   m_rise, m_fall, prev_sck, m_oe;  // Model pins
   logic [7:0]             par2, stage2, latch2;       // Cascaded device and its model
   logic                   srise2;                     // Cascaded rising serial output

   host_model host (.clk(clk_sys), .serial_in(sin), .shift_clock(sck),
      .latch_load(ld), .output_enable(oe));

   shift_and_store_register dut (.CLK_SYS(clk_sys), .RSTN(rstn), .SERIAL_IN(sin),
      .SHIFT_CLOCK(sck), .LATCH_LOAD(ld), .OUTPUT_ENABLE(oe), .PARALLEL_OUT(par),
      .PARALLEL_OUT_OE(par_oe), .SERIAL_OUT_RISE(srise), .SERIAL_OUT_FALL(sfall),
      .LOAD_READY(load_ready), .WORD_VALID(word_valid), .WORD_READY(word_ready),
      .WORD_DATA(word_data));

   // Second device fed from the falling cascade output
   shift_and_store_register next_dev (.CLK_SYS(clk_sys), .RSTN(rstn), .SERIAL_IN(sfall),
      .SHIFT_CLOCK(sck), .LATCH_LOAD(ld), .OUTPUT_ENABLE(oe), .PARALLEL_OUT(par2),
      .PARALLEL_OUT_OE(), .SERIAL_OUT_RISE(srise2), .SERIAL_OUT_FALL(), .LOAD_READY(),
      .WORD_VALID(), .WORD_READY(1'h1), .WORD_DATA());

   // Clock, 8 ns period
   initial begin
      clk_sys = 1'h0;
      forever #4 clk_sys = ~clk_sys;
   end

   // Hang guard
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         stop_test();
      end
   end

   // Compare and count
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Counts, verdict and end of run
   task automatic stop_test();
      $display("compares=%0d mismatches=%0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Reset held 16 cycles, outputs checked while held
   task automatic do_reset();
      host.drive(1'h0, 1'h0, 1'h0, 1'h0);
      rstn = 1'h0;
      repeat (16) @(negedge clk_sys);
      check(par, 8'h00);
      check(par_oe, 8'h00);
      check(8'(load_ready), 8'h01);
      check(8'(word_valid), 8'h00);
      rstn = 1'h1;
      stage = 8'h00;
      latch = 8'h00;
      stage2 = 8'h00;
      latch2 = 8'h00;
      q.delete();
      {m_rise, m_fall, prev_sck, m_oe} = 4'h0;
   endtask

   // One cycle of pins, model update and comparison
   task automatic step(input logic s, input logic c, input logic l, input logic e,
                       input int stall);
      logic       ok;
      logic [7:0] nxt;
      logic [7:0] nxt2;
      host.drive(s, c, l, e);
      word_ready = (($random(seed) & 3) >= stall);
      ok = (q.size() < 2);
      check(8'(load_ready), 8'(ok));
      check(8'(word_valid), 8'(q.size() > 0));
      if (q.size() > 0) check(word_data.bits, q[0]);
      nxt = (c && !prev_sck) ? {stage[6:0], s} : stage;
      nxt2 = (c && !prev_sck) ? {stage2[6:0], m_fall} : stage2;
      if (l) latch2 = nxt2;
      stage2 = nxt2;
      if (!c && prev_sck) m_fall = m_rise;
      if (word_ready && q.size() > 0) q.pop_front();
      if (l && ok && nxt != latch) begin
         latch = nxt;
         q.push_back(nxt);
      end
      stage = nxt;
      m_rise = stage[7];
      prev_sck = c;
      m_oe = e;
      @(posedge clk_sys);
      #1;
      check(par, latch);
      check(par_oe, m_oe ? 8'hff : 8'h00);
      check(8'(srise), 8'(m_rise));
      check(8'(sfall), 8'(m_fall));
      check(par2, latch2);
      check(8'(srise2), 8'(stage2[7]));
   endtask

   // Random pins for n cycles with a given receiver stall level
   task automatic run(input int n, input int stall);
      for (int i = 0; i < n; i++) begin
         step(1'($random(seed)), 1'($random(seed)), 1'($random(seed)), 1'($random(seed)), stall);
      end
   endtask

   // Main sequence
   initial begin
      seed = 93;
      rstn = 1'h0;
      word_ready = 1'h0;
      do_reset();
      for (int i = 0; i < 20; i++) begin
         step(i[1] ^ i[2], i[0], 1'h1, 1'h1, 0);
      end
      $display("test walk done");
      run(60, 4);
      $display("test fill done");
      run(60, 0);
      $display("test drain done");
      run(300, 2);
      $display("test random done");
      do_reset();
      run(200, 1);
      $display("test second reset done");
      stop_test();
   end
endmodule

`default_nettype wire
